// ---- dfcc_core.sv ----
// Feature control command handler with task-file result registers
`timescale 1ns/1ns
`default_nettype none
module dfcc_core
   import dfcc_pkg::*;
#(
   parameter int ADDR_W = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [15:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [15:0] rd_data,
   // Drive events
   input wire logic hard_reset,
   input wire logic setf_wc_valid,
   input wire logic setf_wc_en,
   // Command result
   output logic cmd_done,
   output logic setf_done,
   // Feature state
   output logic wc_active,
   output logic [15:0] id_word85,
   output logic [15:0] temp_interval,
   output logic temp_queue_reset,
   // Non-volatile store request
   output logic nv_save,
   output logic [15:0] nv_feature,
   output logic [15:0] nv_state
);
   typedef struct packed {
      logic [DFCC_KEY_WORDS-1:0][15:0] key;
      logic [7:0] tf_err;
      logic [7:0] tf_scnt;
      logic [7:0] tf_snum;
      logic [7:0] tf_stat;
      logic [15:0] wc_mode;
      logic [15:0] wc_nv;
      logic [15:0] temp;
      logic [15:0] temp_nv;
      logic [3:1] opt;
      logic [3:1] opt_nv;
      logic setf_wc;
      logic wc_on;
      logic done;
      logic sf_done;
      logic qreset;
      logic save;
      logic [15:0] save_feat;
      logic [15:0] save_state;
      logic [15:0] rdata;
   } dfcc_state_t;

   dfcc_state_t s;
   dfcc_state_t n;

   // Address must reach every mapped word
   if (ADDR_W < 4) begin : g_addr_w_check
      $error("dfcc_core needs ADDR_W of at least 4");
   end

   // Feature code to index, zero when undefined
   function automatic logic [1:0] dfcc_feat_idx(input logic [15:0] code);
      logic [1:0] idx;
      idx = 2'h0;
      if (code == FEAT_WCACHE) begin
         idx = 2'h1;
      end else if (code == FEAT_REORDER) begin
         idx = 2'h2;
      end else if (code == FEAT_TEMPLOG) begin
         idx = 2'h3;
      end
      return idx;
   endfunction : dfcc_feat_idx

   // Legal set-state values per feature
   function automatic logic dfcc_state_ok(input logic [1:0] idx,
                                          input logic [15:0] st);
      logic ok;
      ok = 1'b0;
      unique case (idx)
         2'h1: ok = (st == WC_BY_SETF) || (st == WC_FORCE_ON) ||
                    (st == WC_FORCE_OFF);
         2'h2: ok = (st == REORD_ON) || (st == REORD_OFF);
         2'h3: ok = (st != TEMP_INVALID);
         2'h0: ok = 1'b0;
      endcase
      return ok;
   endfunction : dfcc_state_ok

   // Next-state logic
   always_comb begin
      logic [1:0] fidx;
      logic ok;
      logic persist;
      logic [15:0] rval;
      n = s;
      fidx = dfcc_feat_idx(s.key[2]);
      ok = 1'b0;
      persist = s.key[4][OPT_PERSIST_BIT];
      rval = 16'h0000;
      n.done = 1'b0;
      n.sf_done = 1'b0;
      n.qreset = 1'b0;
      n.save = 1'b0;
      n.rdata = 16'h0000;
      // Key sector words written by software
      if (wr_stb && (addr < ADDR_W'(DFCC_KEY_WORDS))) begin
         n.key[addr[2:0]] = wr_data;
      end
      // Set Features is always accepted and remembered
      if (setf_wc_valid) begin
         n.setf_wc = setf_wc_en; // RULE_11
         n.sf_done = 1'b1; // RULE_11
      end
      // Hard reset drops volatile settings
      if (hard_reset) begin
         n.wc_mode = s.wc_nv; // RULE_05
         n.temp = s.temp_nv; // RULE_05
         n.opt = s.opt_nv; // RULE_05
      end
      // Command execution on a write to the go register
      if (wr_stb && (addr == ADDR_W'(REG_GO))) begin
         n.done = 1'b1;
         if ((s.key[0] == ACT_FEATURE) && (fidx != 2'h0)) begin // RULE_01
            unique case (s.key[1]) // RULE_02
               FN_SET: begin
                  ok = dfcc_state_ok(fidx, s.key[3]); // RULE_03 RULE_16
                  if (ok) begin
                     n.opt[fidx] = persist;
                     if (fidx == 2'h1) begin
                        n.wc_mode = s.key[3]; // RULE_10
                     end
                     if (fidx == 2'h3) begin
                        n.temp = s.key[3]; // RULE_15
                        n.qreset = 1'b1;
                     end
                     if (persist) begin
                        n.opt_nv[fidx] = 1'b1; // RULE_04
                        n.save = 1'b1; // RULE_04
                        n.save_feat = s.key[2];
                        n.save_state = s.key[3];
                        if (fidx == 2'h1) begin
                           n.wc_nv = s.key[3]; // RULE_04
                        end
                        if (fidx == 2'h3) begin
                           n.temp_nv = s.key[3]; // RULE_04
                        end
                     end
                  end
               end
               FN_GET_STATE: begin
                  ok = 1'b1;
                  unique case (fidx)
                     2'h1: rval = s.wc_mode;
                     2'h2: rval = REORD_ON; // RULE_14
                     2'h3: rval = s.temp;
                     2'h0: rval = 16'h0000;
                  endcase
               end
               FN_GET_OPT: begin
                  ok = 1'b1;
                  rval = {15'h0000, s.opt[fidx]};
               end
               default: ok = 1'b0; // RULE_16
            endcase
         end
         // Task-file outputs
         if (ok) begin
            n.tf_err = TF_ERR_OK; // RULE_08
            n.tf_stat = TF_STAT_OK; // RULE_08
            n.tf_scnt = rval[7:0]; // RULE_06 RULE_07
            n.tf_snum = rval[15:8]; // RULE_06 RULE_07
         end else begin
            n.tf_err = TF_ERR_ABORT; // RULE_16
            n.tf_stat = TF_STAT_ERR; // RULE_16
            n.tf_scnt = 8'h00;
            n.tf_snum = 8'h00;
         end
      end
      // True write cache operating state
      unique case (n.wc_mode)
         WC_FORCE_ON: n.wc_on = 1'b1; // RULE_10
         WC_FORCE_OFF: n.wc_on = 1'b0; // RULE_10
         default: n.wc_on = n.setf_wc; // RULE_09
      endcase
      // Register reads, data in the following cycle only
      if (rd_stb) begin
         if (addr < ADDR_W'(DFCC_KEY_WORDS)) begin
            n.rdata = s.key[addr[2:0]];
         end else if (addr == ADDR_W'(REG_TF_ERROR)) begin
            n.rdata = {8'h00, s.tf_err};
         end else if (addr == ADDR_W'(REG_TF_SCNT)) begin
            n.rdata = {8'h00, s.tf_scnt};
         end else if (addr == ADDR_W'(REG_TF_SNUM)) begin
            n.rdata = {8'h00, s.tf_snum};
         end else if (addr == ADDR_W'(REG_TF_STATUS)) begin
            n.rdata = {8'h00, s.tf_stat};
         end else if (addr == ADDR_W'(REG_STATUS)) begin
            n.rdata = {14'h0000, s.setf_wc, s.wc_on};
         end else if (addr == ADDR_W'(REG_ID85)) begin
            n.rdata = 16'(s.wc_on) << ID85_WC_BIT; // RULE_12
         end else if (addr == ADDR_W'(REG_TEMP)) begin
            n.rdata = s.temp;
         end
      end
   end

   // State register
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
         s.tf_err <= TF_ERR_OK;
         s.tf_stat <= TF_STAT_OK;
         s.wc_mode <= WC_RESET; // RULE_13
         s.wc_nv <= WC_RESET; // RULE_13
         s.temp <= TEMP_RESET;
         s.temp_nv <= TEMP_RESET;
      end else begin
         s <= n;
      end
   end

   // Outputs from the state register
   assign rd_data = s.rdata;
   assign cmd_done = s.done;
   assign setf_done = s.sf_done;
   assign wc_active = s.wc_on;
   assign id_word85 = 16'(s.wc_on) << ID85_WC_BIT; // RULE_12
   assign temp_interval = s.temp;
   assign temp_queue_reset = s.qreset;
   assign nv_save = s.save;
   assign nv_feature = s.save_feat;
   assign nv_state = s.save_state;

   // Checks
   property p_bad_action;
      @(posedge ref_clk) disable iff (!arst_n)
      (wr_stb && addr == ADDR_W'(REG_GO) && s.key[0] != ACT_FEATURE)
         |=> (s.tf_stat == TF_STAT_ERR) && s.done;
   endproperty
   a_bad_action: assert property (p_bad_action) // RULE_01
      else $error("wrong action code not aborted");

   property p_get_state;
      @(posedge ref_clk) disable iff (!arst_n)
      (wr_stb && addr == ADDR_W'(REG_GO) && s.key[0] == ACT_FEATURE &&
       s.key[1] == FN_GET_STATE && s.key[2] == FEAT_TEMPLOG)
         |=> {s.tf_snum, s.tf_scnt} == $past(s.temp);
   endproperty
   a_get_state: assert property (p_get_state) // RULE_06
      else $error("returned state bytes wrong");

   property p_get_opt;
      @(posedge ref_clk) disable iff (!arst_n)
      (wr_stb && addr == ADDR_W'(REG_GO) && s.key[0] == ACT_FEATURE &&
       s.key[1] == FN_GET_OPT && s.key[2] == FEAT_WCACHE)
         |=> s.tf_snum == 8'h00 && s.tf_scnt == {7'h00, $past(s.opt[1])};
   endproperty
   a_get_opt: assert property (p_get_opt) // RULE_07
      else $error("returned option flag bytes wrong");

   property p_ok_status;
      @(posedge ref_clk) disable iff (!arst_n)
      s.done && s.tf_err == TF_ERR_OK |-> s.tf_stat == TF_STAT_OK;
   endproperty
   a_ok_status: assert property (p_ok_status) // RULE_08
      else $error("success status not 50h");

   property p_forced;
      @(posedge ref_clk) disable iff (!arst_n)
      (s.wc_mode == WC_FORCE_ON |-> s.wc_on) and
      (s.wc_mode == WC_FORCE_OFF |-> !s.wc_on);
   endproperty
   a_forced: assert property (p_forced) // RULE_10
      else $error("forced cache state not applied");

   property p_by_setf;
      @(posedge ref_clk) disable iff (!arst_n)
      s.wc_mode == WC_BY_SETF |-> s.wc_on == s.setf_wc;
   endproperty
   a_by_setf: assert property (p_by_setf) // RULE_09
      else $error("cache not following set features");

   property p_setf_ignored;
      @(posedge ref_clk) disable iff (!arst_n)
      (setf_wc_valid && s.wc_mode != WC_BY_SETF && !hard_reset && !wr_stb)
         |=> $stable(s.wc_on) && s.sf_done;
   endproperty
   a_setf_ignored: assert property (p_setf_ignored) // RULE_11
      else $error("set features changed a forced cache");

   property p_id85;
      @(posedge ref_clk) disable iff (!arst_n)
      id_word85[ID85_WC_BIT] == wc_active;
   endproperty
   a_id85: assert property (p_id85) // RULE_12
      else $error("identify word 85 bit 5 wrong");

   property p_hard_reset;
      @(posedge ref_clk) disable iff (!arst_n)
      (hard_reset && !wr_stb) |=> s.wc_mode == $past(s.wc_nv) &&
                                 s.temp == $past(s.temp_nv);
   endproperty
   a_hard_reset: assert property (p_hard_reset) // RULE_05
      else $error("hard reset did not revert settings");

   property p_temp_zero;
      @(posedge ref_clk) disable iff (!arst_n)
      (wr_stb && addr == ADDR_W'(REG_GO) && s.key[0] == ACT_FEATURE &&
       s.key[1] == FN_SET && s.key[2] == FEAT_TEMPLOG &&
       s.key[3] == TEMP_INVALID) |=> s.tf_err == TF_ERR_ABORT ##1 !s.done;
   endproperty
   a_temp_zero: assert property (p_temp_zero) // RULE_15
      else $error("zero logging interval accepted");

   property p_persist;
      @(posedge ref_clk) disable iff (!arst_n)
      (wr_stb && addr == ADDR_W'(REG_GO) && s.key[0] == ACT_FEATURE &&
       s.key[1] == FN_SET && s.key[2] == FEAT_WCACHE &&
       s.key[3] == WC_FORCE_ON && s.key[4][OPT_PERSIST_BIT])
         |=> s.save && s.wc_nv == WC_FORCE_ON;
   endproperty
   a_persist: assert property (p_persist) // RULE_04
      else $error("persistent set not stored");
endmodule : dfcc_core
`default_nettype wire

// ---- dfcc_pkg.sv ----
// Constants and codes of the feature control command handler
// Notes on behaviour
// RULE_01 - Key word 0 must be action code 0004h for feature control
// RULE_02 - Function 0001h sets, 0002h returns state, 0003h returns option flags
// RULE_03 - Word 2 selects the feature, word 3 carries its requested state
// RULE_04 - Option bit 0 one on set keeps the new state across power cycles
// RULE_05 - Option bit 0 zero gives a volatile change; hard reset reverts it
// RULE_06 - Return-state puts state low byte in count, high byte in number
// RULE_07 - Return-flags puts flags low byte in count, high byte in number
// RULE_08 - Success reports error 00h and status 50h, other fields reserved
// RULE_09 - Cache feature state 0001h lets Set Features decide the write cache
// RULE_10 - Cache state 0002h forces cache on, 0003h forces it off
// RULE_11 - Set Features cache changes complete normally but do nothing while forced
// RULE_12 - Identify word 85 bit 5 always shows the true write cache state
// RULE_13 - Cache feature defaults to Set Features control
// RULE_14 - Reordering defaults on; disabling state 0002h is accepted but ignored
// RULE_15 - Temperature feature sets logging minutes 0001h..FFFFh; zero is invalid
// RULE_16 - Unknown function, feature or state codes abort with error status
package dfcc_pkg;
   localparam int DFCC_WORD_W = 16;
   localparam int DFCC_KEY_WORDS = 5;
   // Key sector codes
   localparam logic [15:0] ACT_FEATURE = 16'h0004;
   localparam logic [15:0] FN_SET = 16'h0001;
   localparam logic [15:0] FN_GET_STATE = 16'h0002;
   localparam logic [15:0] FN_GET_OPT = 16'h0003;
   localparam logic [15:0] FEAT_WCACHE = 16'h0001;
   localparam logic [15:0] FEAT_REORDER = 16'h0002;
   localparam logic [15:0] FEAT_TEMPLOG = 16'h0003;
   localparam logic [15:0] WC_BY_SETF = 16'h0001;
   localparam logic [15:0] WC_FORCE_ON = 16'h0002;
   localparam logic [15:0] WC_FORCE_OFF = 16'h0003;
   localparam logic [15:0] REORD_ON = 16'h0001;
   localparam logic [15:0] REORD_OFF = 16'h0002;
   localparam logic [15:0] TEMP_INVALID = 16'h0000;
   localparam int OPT_PERSIST_BIT = 0;
   localparam int ID85_WC_BIT = 5;
   // Reset values and task-file result codes
   localparam logic [15:0] WC_RESET = 16'h0001;
   localparam logic [15:0] TEMP_RESET = 16'h0001;
   localparam logic [7:0] TF_ERR_OK = 8'h00;
   localparam logic [7:0] TF_STAT_OK = 8'h50;
   localparam logic [7:0] TF_ERR_ABORT = 8'h04;
   localparam logic [7:0] TF_STAT_ERR = 8'h51;
   // Register word offsets
   localparam logic [3:0] REG_KEY_BASE = 4'h0;
   localparam logic [3:0] REG_GO = 4'h5;
   localparam logic [3:0] REG_TF_ERROR = 4'h6;
   localparam logic [3:0] REG_TF_SCNT = 4'h7;
   localparam logic [3:0] REG_TF_SNUM = 4'h8;
   localparam logic [3:0] REG_TF_STATUS = 4'h9;
   localparam logic [3:0] REG_STATUS = 4'hA;
   localparam logic [3:0] REG_ID85 = 4'hB;
   localparam logic [3:0] REG_TEMP = 4'hC;
endpackage : dfcc_pkg

// ---- dfcc_note_end.sv ----
// Spare source unit that holds no logic of the block
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ---- dfcc_host_model.sv ----
// Host-side model issuing feature control commands over the register port
`timescale 1ns/1ns
`default_nettype none
module dfcc_host_model
   import dfcc_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Register port
   output logic [3:0] addr,
   output logic [15:0] wr_data,
   output logic wr_stb,
   output logic rd_stb,
   input wire logic [15:0] rd_data
);
   // Idle bus from time zero
   initial begin
      addr = 4'h0;
      wr_data = 16'h0000;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
   end

   // One-cycle write; data inverted afterwards so stale values never match
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
      wr_data <= ~d;
   endtask : wr

   // One-cycle read; data taken in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1 d = rd_data;
   endtask : rd

   // Key sector words then go; returns just after the go edge
   task automatic cmd(input logic [15:0] act, fn, feat, st, opt);
      wr(REG_KEY_BASE, act);
      wr(4'h1, fn);
      wr(4'h2, feat);
      wr(4'h3, st);
      wr(4'h4, opt);
      wr(REG_GO, 16'h0001);
      #1;
   endtask : cmd
endmodule : dfcc_host_model
`default_nettype wire

// ---- drive_feature_control_cmd_tb_top.sv ----
// Self-checking testbench of the feature control command handler
`timescale 1ns/1ns
`default_nettype none
module drive_feature_control_cmd_tb_top
   import dfcc_pkg::*;
;
   logic ref_clk, arst_n, wr_stb, rd_stb, hard_reset, setf_wc_valid;
   logic setf_wc_en, cmd_done, setf_done, wc_active, temp_queue_reset;
   logic nv_save;
   logic [3:0] addr;
   logic [15:0] wr_data, rd_data, id_word85, temp_interval;
   logic [15:0] nv_feature, nv_state;
   int num_errors = 0;
   int cmp_count = 0;

   // Device under test and host model
   dfcc_core u_dfcc_core (.ref_clk(ref_clk), .arst_n(arst_n), .addr(addr),
      .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rd_data(rd_data), .hard_reset(hard_reset),
      .setf_wc_valid(setf_wc_valid), .setf_wc_en(setf_wc_en),
      .cmd_done(cmd_done), .setf_done(setf_done), .wc_active(wc_active),
      .id_word85(id_word85), .temp_interval(temp_interval),
      .temp_queue_reset(temp_queue_reset), .nv_save(nv_save),
      .nv_feature(nv_feature), .nv_state(nv_state));
   dfcc_host_model u_dfcc_host_model (.ref_clk(ref_clk), .addr(addr),
      .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rd_data(rd_data));

   // 250 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Task-file result registers after a command
   task automatic tf(input logic [7:0] e, c, n, s);
      logic [15:0] d;
      check({15'h0000, cmd_done}, 16'h0001);
      u_dfcc_host_model.rd(REG_TF_ERROR, d);
      check(d, {8'h00, e});
      u_dfcc_host_model.rd(REG_TF_SCNT, d);
      check(d, {8'h00, c});
      u_dfcc_host_model.rd(REG_TF_SNUM, d);
      check(d, {8'h00, n});
      u_dfcc_host_model.rd(REG_TF_STATUS, d);
      check(d, {8'h00, s});
   endtask : tf

   task automatic run(input logic [15:0] fn, feat, st, opt);
      u_dfcc_host_model.cmd(ACT_FEATURE, fn, feat, st, opt);
   endtask : run

   // Set Features write-cache pulse
   task automatic setf(input logic en);
      @(posedge ref_clk);
      setf_wc_valid <= 1'b1;
      setf_wc_en <= en;
      @(posedge ref_clk);
      setf_wc_valid <= 1'b0;
      #1 check({15'h0000, setf_done}, 16'h0001);
   endtask : setf

   task automatic hrst();
      @(posedge ref_clk);
      hard_reset <= 1'b1;
      @(posedge ref_clk);
      hard_reset <= 1'b0;
      #1;
   endtask : hrst

   task automatic wc(input logic e);
      check({15'h0000, wc_active}, {15'h0000, e});
      check(id_word85, {10'h000, e, 5'h00});
   endtask : wc

   // Defaults after power-on reset
   task automatic t_defaults();
      logic [15:0] d;
      check(temp_interval, TEMP_RESET);
      wc(1'b0);
      run(FN_GET_STATE, FEAT_WCACHE, 16'h0000, 16'h0000);
      tf(TF_ERR_OK, 8'h01, 8'h00, TF_STAT_OK);
      run(FN_GET_STATE, FEAT_REORDER, 16'h0000, 16'h0000);
      tf(TF_ERR_OK, 8'h01, 8'h00, TF_STAT_OK);
      u_dfcc_host_model.rd(4'hF, d);
      check(d, 16'h0000);
   endtask : t_defaults

   // Forcing the write cache against Set Features
   task automatic t_cache();
      setf(1'b1);
      wc(1'b1);
      run(FN_SET, FEAT_WCACHE, WC_FORCE_OFF, 16'h0000);
      tf(TF_ERR_OK, 8'h00, 8'h00, TF_STAT_OK);
      wc(1'b0);
      setf(1'b1);
      wc(1'b0);
      run(FN_SET, FEAT_WCACHE, WC_FORCE_ON, 16'h0000);
      wc(1'b1);
      setf(1'b0);
      wc(1'b1);
      run(FN_GET_STATE, FEAT_WCACHE, 16'h0000, 16'h0000);
      tf(TF_ERR_OK, 8'h02, 8'h00, TF_STAT_OK);
      hrst();
      wc(1'b0);
      run(FN_GET_STATE, FEAT_WCACHE, 16'h0000, 16'h0000);
      tf(TF_ERR_OK, 8'h01, 8'h00, TF_STAT_OK);
   endtask : t_cache

   // Persistent and volatile temperature interval
   task automatic t_persist();
      logic [15:0] d;
      run(FN_SET, FEAT_TEMPLOG, 16'h1234, 16'h0001);
      check({15'h0000, nv_save}, 16'h0001);
      check({15'h0000, temp_queue_reset}, 16'h0001);
      check(nv_feature, FEAT_TEMPLOG);
      check(nv_state, 16'h1234);
      check(temp_interval, 16'h1234);
      run(FN_GET_STATE, FEAT_TEMPLOG, 16'h0000, 16'h0000);
      tf(TF_ERR_OK, 8'h34, 8'h12, TF_STAT_OK);
      run(FN_GET_OPT, FEAT_TEMPLOG, 16'h0000, 16'h0000);
      tf(TF_ERR_OK, 8'h01, 8'h00, TF_STAT_OK);
      run(FN_SET, FEAT_TEMPLOG, 16'hFFFF, 16'h0000);
      check({15'h0000, nv_save}, 16'h0000);
      check(temp_interval, 16'hFFFF);
      run(FN_GET_OPT, FEAT_TEMPLOG, 16'h0000, 16'h0000);
      tf(TF_ERR_OK, 8'h00, 8'h00, TF_STAT_OK);
      hrst();
      check(temp_interval, 16'h1234);
      // Persistent forced cache survives a hard reset
      run(FN_SET, FEAT_WCACHE, WC_FORCE_ON, 16'h0001);
      check({15'h0000, nv_save}, 16'h0001);
      check(nv_feature, FEAT_WCACHE);
      check(nv_state, WC_FORCE_ON);
      run(FN_GET_OPT, FEAT_WCACHE, 16'h0000, 16'h0000);
      tf(TF_ERR_OK, 8'h01, 8'h00, TF_STAT_OK);
      setf(1'b0);
      hrst();
      wc(1'b1);
      u_dfcc_host_model.rd(REG_ID85, d);
      check(d, 16'h0020);
   endtask : t_persist

   // Illegal codes abort without changing state
   task automatic t_abort();
      logic [15:0] bad [6][4] = '{
         '{16'h0005, FN_SET, FEAT_TEMPLOG, 16'h0007},
         '{ACT_FEATURE, 16'h0004, FEAT_TEMPLOG, 16'h0007},
         '{ACT_FEATURE, 16'h0000, FEAT_TEMPLOG, 16'h0007},
         '{ACT_FEATURE, FN_SET, 16'h0004, 16'h0007},
         '{ACT_FEATURE, FN_SET, FEAT_TEMPLOG, TEMP_INVALID},
         '{ACT_FEATURE, FN_SET, FEAT_WCACHE, 16'h0004}};
      for (int i = 0; i < 6; i++) begin
         u_dfcc_host_model.cmd(bad[i][0], bad[i][1], bad[i][2], bad[i][3],
            16'h0000);
         tf(TF_ERR_ABORT, 8'h00, 8'h00, TF_STAT_ERR);
         check(temp_interval, 16'h1234);
      end
      run(FN_SET, FEAT_REORDER, REORD_OFF, 16'h0000);
      tf(TF_ERR_OK, 8'h00, 8'h00, TF_STAT_OK);
      run(FN_GET_STATE, FEAT_REORDER, 16'h0000, 16'h0000);
      tf(TF_ERR_OK, 8'h01, 8'h00, TF_STAT_OK);
   endtask : t_abort

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : final_report

   // Main sequence
   initial begin
      arst_n = 1'b0;
      hard_reset = 1'b0;
      setf_wc_valid = 1'b0;
      setf_wc_en = 1'b0;
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      t_defaults();
      t_cache();
      t_persist();
      t_abort();
      final_report();
   end

   // Watchdog against a hang
   initial begin
      #40000;
      num_errors++;
      final_report();
   end
endmodule : drive_feature_control_cmd_tb_top
`default_nettype wire
